// File: rtl/agfs_button.sv
// Purpose: mode button press timer
// Assumes: btn already synchronised to clk
// Notes: one long pulse per press held LONG_CYC cycles, else one short pulse on release; holding on never repeats
`default_nettype none
module agfs_button #(
  parameter int unsigned LONG_CYC = agfs_pkg::LONG_PRESS_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic btn,
  output var logic long_p,
  output var logic short_p
);
  import agfs_pkg::*;
  logic [31:0] hold_reg;
  logic fired_reg;
  logic btn_q_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= 32'h0;
      fired_reg <= 1'b0;
      btn_q_reg <= 1'b0;
      long_p <= 1'b0;
      short_p <= 1'b0;
    end else begin
      btn_q_reg <= btn;
      long_p <= 1'b0;
      short_p <= 1'b0;
      if (btn) begin
        if (!fired_reg) begin
          hold_reg <= hold_reg + 32'h1;
        end
        if (!fired_reg && hold_reg == 32'(LONG_CYC - 1)) begin
          fired_reg <= 1'b1;
          long_p <= 1'b1;
        end
      end else begin
        hold_reg <= 32'h0;
        fired_reg <= 1'b0;
        if (btn_q_reg && !fired_reg) begin
          short_p <= 1'b1;
        end
      end
    end
  end
endmodule : agfs_button
`default_nettype wire

// File: rtl/agfs_pkg.sv
// Purpose: shared constants and types of the converter fault/mode block
// Assumes: 125 MHz clock, classic wishbone register access
// Notes: status bytes mirror the three host-visible input bytes
// Operation
// - byte X+18 carries the error flag in bit 1 and the data-valid flag in bit 0 per condition.
// - a configuration mismatch lights its lamp, keeps error 0 and valid 1, and clears X+16 bit 7.
// - in protection mode the show button steps through the mismatching slave addresses.
// - low supply lights its lamp, shows 88, sets error, clears valid, and recovers by itself.
// - a config store fault shows E1, clears X+17 bit 2 and voids the registered configuration.
// - master, ROM, RAM and watchdog-1 faults show E0, E2, E3, E8 and set X+18 bits 2 to 5.
// - host-link watchdog expiry lights the error lamp, shows E6 and leaves status not valid.
// - watchdog 2 (E9 or tens dot) and host-link RAM fault (E7) light the error lamp.
// - a long-press entry to protection mode stores the slave configuration and enables auto addressing; a short press does neither.
// - the operating mode is kept in non-volatile storage across power cycles.
// - the operating mode changes only through the mode button.
// - mode switching and registration work without the host link present.
// - a 5 s mode press registers and enters protection, or returns protection to configuration.
// - a slave present at address 0 refuses registration, keeps configuration mode and shows E5.
`default_nettype none
package agfs_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned LONG_PRESS_S = 5;
  localparam int unsigned LONG_PRESS_CYC = CLK_HZ * LONG_PRESS_S;
  localparam int unsigned SHOW_STEP_S = 1;
  localparam int unsigned SHOW_STEP_CYC = CLK_HZ * SHOW_STEP_S;
  localparam logic [2:0] SWITCH_CYC = 3'h4;
  localparam logic [1:0] BOOT_CYC = 2'h3;

  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_DISPLAY = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADR_REG_CFG = 8'h10;
  localparam logic [7:0] ADR_MISMATCH = 8'h14;
  localparam logic [7:0] ADR_PRESENT = 8'h18;

  localparam int IRQ_MISMATCH = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_MODE = 2;
  localparam int IRQ_REFUSE = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  localparam int X16_MATCH = 7;
  localparam int X16_INIT = 0;
  localparam int X17_NV_OK = 2;
  localparam int X17_SWITCH = 0;
  localparam int X18_VALID = 0;
  localparam int X18_ERR = 1;
  localparam int X18_MASTER = 2;
  localparam int X18_ROM = 3;
  localparam int X18_RAM = 4;
  localparam int X18_WD1 = 5;

  localparam logic [7:0] SEG_BLANK = 8'hFF;
  localparam logic [7:0] SEG_88 = 8'h88;
  localparam logic [7:0] SEG_E0 = 8'hE0;
  localparam logic [7:0] SEG_E1 = 8'hE1;
  localparam logic [7:0] SEG_E2 = 8'hE2;
  localparam logic [7:0] SEG_E3 = 8'hE3;
  localparam logic [7:0] SEG_E5 = 8'hE5;
  localparam logic [7:0] SEG_E6 = 8'hE6;
  localparam logic [7:0] SEG_E7 = 8'hE7;
  localparam logic [7:0] SEG_E8 = 8'hE8;
  localparam logic [7:0] SEG_E9 = 8'hE9;

  typedef enum logic {MODE_CONFIG, MODE_PROTECT} agfs_mode_e;

  typedef struct packed {
    logic supply_low;
    logic nv_fault;
    logic master_fault;
    logic rom_fault;
    logic ram_fault;
    logic wd1;
    logic wd2;
    logic link_wd;
    logic link_ram;
    logic init_busy;
  } agfs_faults_s;

  typedef struct packed {
    logic [7:0] x18;
    logic [7:0] x17;
    logic [7:0] x16;
  } agfs_status_s;

  typedef struct packed {
    logic config_mismatch_lamp;
    logic supply_low_lamp;
    logic error_lamp;
    logic config_mode_lamp;
    logic auto_addr_lamp;
  } agfs_lamps_s;
endpackage : agfs_pkg
`default_nettype wire

// File: rtl/agfs_top.sv
// Purpose: fault reporting and operating mode of the link-to-network converter
// Assumes: all pin inputs asynchronous; wishbone master on clk
// Notes: mode survives power loss only through the external nv store pins
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`default_nettype none
module agfs_top #(
  parameter int unsigned LONG_CYC = agfs_pkg::LONG_PRESS_CYC,
  parameter int unsigned STEP_CYC = agfs_pkg::SHOW_STEP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire agfs_pkg::agfs_faults_s faults_i,
  input wire logic [31:0] present_i,
  input wire logic mode_button,
  input wire logic show_button,
  input wire logic nv_mode_i,
  output logic nv_mode_o,
  output logic nv_mode_wr_o,
  output var agfs_pkg::agfs_status_s status_o,
  output var agfs_pkg::agfs_lamps_s lamps_o,
  output logic [7:0] seg_o,
  output logic dot_tens_o,
  output logic irq_o
);
  import agfs_pkg::*;

  function automatic logic [5:0] first_at(input logic [31:0] v, input logic [5:0] s);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i] && 6'(i) >= s) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : first_at

  function automatic logic [7:0] to_dec(input logic [4:0] a);
    return {4'(a / 5'h0A), 4'(a % 5'h0A)};
  endfunction : to_dec

  // all pins share one two-stage synchroniser
  logic [44:0] sync1_reg;
  logic [44:0] sync2_reg;
  agfs_faults_s flt;
  logic [31:0] present;
  logic mode_btn;
  logic show_btn;
  logic nv_in;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 45'h0;
      sync2_reg <= 45'h0;
    end else begin
      sync1_reg <= {faults_i, present_i, mode_button, show_button, nv_mode_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign flt = agfs_faults_s'(sync2_reg[44:35]);
  assign present = sync2_reg[34:3];
  assign mode_btn = sync2_reg[2];
  assign show_btn = sync2_reg[1];
  assign nv_in = sync2_reg[0];

  logic long_p;
  logic short_p;

  agfs_button #(
    .LONG_CYC(LONG_CYC)
  ) u_mode_btn (
    .clk(clk),
    .nrst(nrst),
    .btn(mode_btn),
    .long_p(long_p),
    .short_p(short_p)
  );

  // boot: wait for the synchroniser, then load the stored mode
  logic [1:0] boot_reg;
  logic booted;
  assign booted = (boot_reg == BOOT_CYC);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_reg <= 2'h0;
    end else if (!booted) begin
      boot_reg <= boot_reg + 2'h1;
    end
  end

  // mode machine; no register write can reach it
  agfs_mode_e mode_reg;
  logic auto_reg;
  logic [31:0] cfg_reg;
  logic cfg_ok_reg;
  logic refuse_reg;
  logic refuse_ev_reg;
  logic mode_ev_reg;
  logic [2:0] sw_cnt_reg;
  logic nv_wr_reg;
  logic nv_val_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_CONFIG;
      auto_reg <= 1'b0;
      cfg_reg <= 32'h0;
      cfg_ok_reg <= 1'b0;
      refuse_reg <= 1'b0;
      refuse_ev_reg <= 1'b0;
      mode_ev_reg <= 1'b0;
      sw_cnt_reg <= 3'h0;
      nv_wr_reg <= 1'b0;
      nv_val_reg <= 1'b0;
    end else begin
      nv_wr_reg <= 1'b0;
      mode_ev_reg <= 1'b0;
      refuse_ev_reg <= 1'b0;
      if (sw_cnt_reg != 3'h0) begin
        sw_cnt_reg <= sw_cnt_reg - 3'h1;
      end
      if (flt.nv_fault) begin
        cfg_ok_reg <= 1'b0;
      end
      if (boot_reg == BOOT_CYC - 2'h1) begin
        mode_reg <= agfs_mode_e'(nv_in);
        nv_val_reg <= nv_in;
      end else if (booted && (long_p || short_p)) begin
        refuse_reg <= 1'b0;
        case (mode_reg)
          MODE_CONFIG: begin
            if (long_p && present[0]) begin
              refuse_reg <= 1'b1;
              refuse_ev_reg <= 1'b1;
            end else begin
              if (long_p) begin
                cfg_reg <= present;
                // fault in the same cycle keeps the set void
                cfg_ok_reg <= !flt.nv_fault;
                auto_reg <= 1'b1;
              end
              mode_reg <= MODE_PROTECT;
              mode_ev_reg <= 1'b1;
              sw_cnt_reg <= SWITCH_CYC;
              nv_wr_reg <= 1'b1;
              nv_val_reg <= 1'b1;
            end
          end
          MODE_PROTECT: begin
            if (long_p) begin
              mode_reg <= MODE_CONFIG;
              auto_reg <= 1'b0;
              mode_ev_reg <= 1'b1;
              sw_cnt_reg <= SWITCH_CYC;
              nv_wr_reg <= 1'b1;
              nv_val_reg <= 1'b0;
            end
          end
          default: begin
            mode_reg <= MODE_CONFIG;
          end
        endcase
      end
    end
  end

  logic [31:0] mism_vec;
  logic mismatch;
  logic [5:0] mism_first;
  assign mism_vec = (mode_reg == MODE_PROTECT) ? (cfg_reg ^ present) : 32'h0;
  assign mismatch = |mism_vec;
  assign mism_first = first_at(mism_vec, 6'h00);

  // show sequencer, about one address per second
  logic show_q_reg;
  logic show_run_reg;
  logic [4:0] show_idx_reg;
  logic [31:0] tick_reg;
  logic [31:0] show_vec;
  logic [5:0] show_first;
  logic [5:0] show_nxt;
  assign show_vec = (mode_reg == MODE_PROTECT) ? mism_vec : present;
  assign show_first = first_at(show_vec, 6'h00);
  assign show_nxt = first_at(show_vec, {1'b0, show_idx_reg} + 6'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      show_q_reg <= 1'b0;
      show_run_reg <= 1'b0;
      show_idx_reg <= 5'h00;
      tick_reg <= 32'h0;
    end else begin
      show_q_reg <= show_btn;
      if (!show_run_reg) begin
        if (show_btn && !show_q_reg && show_first[5]) begin
          show_run_reg <= 1'b1;
          show_idx_reg <= show_first[4:0];
          tick_reg <= 32'h0;
        end
      end else if (tick_reg == 32'(STEP_CYC - 1)) begin
        tick_reg <= 32'h0;
        show_run_reg <= show_nxt[5];
        show_idx_reg <= show_nxt[4:0];
      end else begin
        tick_reg <= tick_reg + 32'h1;
      end
    end
  end

  // indication next values
  agfs_status_s status_next;
  agfs_lamps_s lamps_next;
  logic [7:0] seg_next;
  logic dot_next;
  logic err;
  logic busy;
  assign busy = flt.init_busy || !booted || (sw_cnt_reg != 3'h0);

  always_comb begin
    err = flt.supply_low || flt.nv_fault || flt.master_fault || flt.rom_fault || flt.ram_fault || flt.wd1
          || flt.wd2;
    status_next = '0;
    status_next.x18[X18_ERR] = err;
    status_next.x18[X18_VALID] = !err && !busy && !flt.link_wd && !flt.link_ram;
    status_next.x18[X18_MASTER] = flt.master_fault;
    status_next.x18[X18_ROM] = flt.rom_fault;
    status_next.x18[X18_RAM] = flt.ram_fault;
    status_next.x18[X18_WD1] = flt.wd1;
    status_next.x17[X17_NV_OK] = !flt.nv_fault;
    status_next.x17[X17_SWITCH] = sw_cnt_reg != 3'h0;
    status_next.x16[X16_INIT] = flt.init_busy || !booted;
    status_next.x16[X16_MATCH] = !mismatch;
    lamps_next.config_mismatch_lamp = mismatch;
    lamps_next.supply_low_lamp = flt.supply_low;
    lamps_next.error_lamp = flt.nv_fault || flt.master_fault || flt.rom_fault || flt.ram_fault || flt.wd1
                            || flt.wd2 || flt.link_wd || flt.link_ram;
    lamps_next.config_mode_lamp = mode_reg == MODE_CONFIG;
    lamps_next.auto_addr_lamp = auto_reg && mode_reg == MODE_PROTECT;
    seg_next = SEG_BLANK;
    dot_next = flt.wd2;
    if (flt.wd2) begin
      seg_next = SEG_E9;
    end else if (flt.link_wd) begin
      seg_next = SEG_E6;
    end else if (flt.link_ram) begin
      seg_next = SEG_E7;
    end else if (flt.master_fault) begin
      seg_next = SEG_E0;
    end else if (flt.nv_fault) begin
      seg_next = SEG_E1;
    end else if (flt.rom_fault) begin
      seg_next = SEG_E2;
    end else if (flt.ram_fault) begin
      seg_next = SEG_E3;
    end else if (flt.wd1) begin
      seg_next = SEG_E8;
    end else if (flt.supply_low || busy) begin
      seg_next = SEG_88;
    end else if (refuse_reg) begin
      seg_next = SEG_E5;
    end else if (show_run_reg) begin
      seg_next = to_dec(show_idx_reg);
    end else if (mismatch) begin
      seg_next = to_dec(mism_first[4:0]);
    end
  end

  agfs_status_s status_reg;
  agfs_lamps_s lamps_reg;
  logic [7:0] seg_reg;
  logic dot_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
      lamps_reg <= '0;
      seg_reg <= SEG_88;
      dot_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      lamps_reg <= lamps_next;
      seg_reg <= seg_next;
      dot_reg <= dot_next;
    end
  end

  // wishbone slave, one wait state per access
  logic req;
  logic wr;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  logic [3:0] stat_reg;
  logic [3:0] mask_reg;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [3:0] stat_next;
  logic irq_reg;
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign ev = {refuse_ev_reg, mode_ev_reg, status_next.x18[X18_ERR] && !status_reg.x18[X18_ERR],
               mismatch && !lamps_reg.config_mismatch_lamp};
  assign clr = (wr && wb_adr_i == ADR_IRQ_STAT) ? wb_dat_i[3:0] : 4'h0;
  // new events win over a clear in the same cycle
  assign stat_next = (stat_reg & ~clr) | ev;

  always_comb begin
    case (wb_adr_i)
      ADR_STATUS: rd_data = {8'h00, status_reg};
      ADR_DISPLAY: rd_data = {18'h0, dot_reg, lamps_reg, seg_reg};
      ADR_IRQ_STAT: rd_data = {28'h0, stat_reg};
      ADR_IRQ_MASK: rd_data = {28'h0, mask_reg};
      ADR_REG_CFG: rd_data = cfg_reg;
      ADR_MISMATCH: rd_data = mism_vec;
      ADR_PRESENT: rd_data = present;
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      stat_reg <= 4'h0;
      mask_reg <= IRQ_MASK_RST;
      irq_reg <= 1'b0;
    end else begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= rd_data;
      end
      if (wr && wb_adr_i == ADR_IRQ_MASK) begin
        mask_reg <= wb_dat_i[3:0];
      end
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign status_o = status_reg;
  assign lamps_o = lamps_reg;
  assign seg_o = seg_reg;
  assign dot_tens_o = dot_reg;
  assign nv_mode_o = nv_val_reg;
  assign nv_mode_wr_o = nv_wr_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_ERR_VALID: assert property (status_reg.x18[X18_ERR] |-> !status_reg.x18[X18_VALID])
    else $error("error flag with data valid");
  AST_MISMATCH: assert property (mismatch && !err |=> lamps_reg.config_mismatch_lamp
    && !status_reg.x16[X16_MATCH] && !status_reg.x18[X18_ERR])
    else $error("mismatch not reported");
  AST_SHOW: assert property (show_btn && !show_q_reg && !show_run_reg && mode_reg == MODE_PROTECT
    && mismatch |=> show_run_reg && {1'b1, show_idx_reg} == $past(mism_first))
    else $error("show did not start at first mismatch");
  AST_SUPPLY: assert property (flt.supply_low |=> lamps_reg.supply_low_lamp
    && status_reg.x18[X18_ERR] && !status_reg.x18[X18_VALID])
    else $error("supply low not reported");
  AST_SUPPLY_OFF: assert property ($fell(flt.supply_low) |=> !lamps_reg.supply_low_lamp)
    else $error("supply low lamp stuck");
  AST_NV: assert property (flt.nv_fault |=> !status_reg.x17[X17_NV_OK] && !cfg_ok_reg)
    else $error("store fault not reported");
  AST_ROM: assert property (flt.rom_fault && !flt.wd2 && !flt.link_wd && !flt.link_ram
    && !flt.master_fault && !flt.nv_fault |=> status_reg.x18[X18_ROM] && seg_reg == SEG_E2)
    else $error("rom fault not reported");
  AST_LINK_WD: assert property (flt.link_wd && !flt.wd2 |=> lamps_reg.error_lamp
    && seg_reg == SEG_E6 && !status_reg.x18[X18_VALID])
    else $error("link watchdog not reported");
  AST_WD2: assert property (flt.wd2 |=> lamps_reg.error_lamp && dot_reg && seg_reg == SEG_E9)
    else $error("watchdog 2 not reported");
  AST_REGISTER: assert property (booted && mode_reg == MODE_CONFIG && long_p && !present[0]
    |=> mode_reg == MODE_PROTECT && auto_reg && cfg_reg == $past(present))
    else $error("registration missing on protect entry");
  AST_NV_WRITE: assert property (booted && $past(booted) && mode_reg != $past(mode_reg)
    |-> nv_wr_reg && nv_val_reg == mode_reg)
    else $error("mode change not stored");
  AST_BTN_ONLY: assert property (booted && $past(booted) && mode_reg != $past(mode_reg)
    |-> $past(long_p) || $past(short_p))
    else $error("mode changed without button");
  AST_ADDR0: assert property (booted && mode_reg == MODE_CONFIG && long_p && present[0]
    |=> mode_reg == MODE_CONFIG && refuse_reg ##1 stat_reg[IRQ_REFUSE])
    else $error("address 0 not refused");
endmodule : agfs_top
`default_nettype wire

// File: testbench/agfs_nv_model.sv
// Purpose: non-volatile mode store at the far side of the mode pins
// Assumes: written by a one-cycle pulse, read back at any time
// Notes: no reset on purpose, the stored mode must outlive every reset
`default_nettype none
module agfs_nv_model (
  input wire logic clk,
  input wire logic wr,
  input wire logic d,
  output var logic q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial q = 1'b0;
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      q <= d;
    end
  end
endmodule : agfs_nv_model
`default_nettype wire

// File: testbench/asi_gateway_fault_status_tb.sv
// Purpose: directed bench for the converter fault and mode block
// Assumes: long press and show step shortened to 20 and 8 cycles
// Notes: fault, mode and show checks are taken at the ports, registers by wishbone
`default_nettype none
module asi_gateway_fault_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import agfs_pkg::*;
  logic clk, nrst, cyc, stb, we, mbtn, sbtn, nvq, nvd, nvwr, dot, irq, ack;
  logic [7:0] adr, seg;
  logic [3:0] sel;
  logic [31:0] dat, rdat, present, q;
  agfs_faults_s flt;
  agfs_status_s st;
  agfs_lamps_s lmp;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] e_seg [10] = '{SEG_88, SEG_E1, SEG_E0, SEG_E2, SEG_E3, SEG_E8, SEG_E9, SEG_E6, SEG_E7, SEG_88};
  logic [7:0] e_x18 [10] = '{8'h02, 8'h02, 8'h06, 8'h0A, 8'h12, 8'h22, 8'h02, 8'h00, 8'h00, 8'h00};

  agfs_top #(.LONG_CYC(20), .STEP_CYC(8)) u_dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .faults_i(flt),
    .present_i(present), .mode_button(mbtn), .show_button(sbtn), .nv_mode_i(nvq), .nv_mode_o(nvd),
    .nv_mode_wr_o(nvwr), .status_o(st), .lamps_o(lmp), .seg_o(seg), .dot_tens_o(dot), .irq_o(irq)
  );
  agfs_nv_model u_nv (.clk(clk), .wr(nvwr), .d(nvd), .q(nvq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one classic cycle; read data lands in q at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    // no local limit: only the watchdog ends a missing answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // hold long enough for the shortened long press, then let switching settle
  task press;
    mbtn <= 1'b1;
    repeat (30) @(posedge clk);
    mbtn <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : press

  task do_reset;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : do_reset

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    mbtn = 1'b0;
    sbtn = 1'b0;
    present = 32'h0;
    flt = '0;
    do_reset();
    chk(st, 24'h010480, "normal status");
    for (int i = 0; i < 10; i++) begin
      flt <= agfs_faults_s'(10'h200 >> i);
      repeat (6) @(posedge clk);
      chk(seg, e_seg[i], "fault code");
      chk(st.x18, e_x18[i], "x18 flags");
      chk({lmp.error_lamp, lmp.supply_low_lamp, dot}, {i > 0 && i < 9, i == 0, i == 6}, "lamps");
      chk({st.x17[X17_NV_OK], st.x16[X16_INIT]}, {i != 1, i == 9}, "x17 x16");
    end
    flt <= '0;
    repeat (6) @(posedge clk);
    chk(st, 24'h010480, "recovered");
    wb(1'b1, ADR_IRQ_STAT, 32'hF);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    chk(q, 32'h0, "irq status cleared");
    wb(1'b0, ADR_IRQ_MASK, 32'h0);
    chk(q, 32'h0, "mask reset value");
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, ADR_IRQ_MASK, 32'h8);
    present <= 32'h1;
    repeat (4) @(posedge clk);
    press();
    chk({seg, lmp.config_mode_lamp, irq, nvq}, {SEG_E5, 3'b110}, "address 0 refusal");
    wb(1'b1, ADR_IRQ_STAT, 32'h8);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
    present <= 32'h6;
    flt <= agfs_faults_s'(10'h004);
    repeat (4) @(posedge clk);
    press();
    chk({lmp.config_mode_lamp, lmp.auto_addr_lamp, nvq}, 3'b011, "protect entry");
    flt <= '0;
    wb(1'b1, ADR_STATUS, 32'hFFFFFFFF);
    wb(1'b1, ADR_REG_CFG, 32'h0);
    wb(1'b0, ADR_REG_CFG, 32'h0);
    chk(q, 32'h6, "registered config");
    chk(lmp.config_mode_lamp, 1'b0, "mode after bus writes");
    present <= 32'h0;
    repeat (6) @(posedge clk);
    chk(st, 24'h010400, "mismatch status");
    chk({lmp.config_mismatch_lamp, seg}, 9'h101, "mismatch lamp and code");
    wb(1'b0, ADR_MISMATCH, 32'h0);
    chk(q, 32'h6, "mismatch vector");
    wb(1'b0, ADR_DISPLAY, 32'h0);
    chk(q, 32'h00001101, "display word");
    sbtn <= 1'b1;
    repeat (3) @(posedge clk);
    sbtn <= 1'b0;
    repeat (12) @(posedge clk);
    chk(seg, 8'h02, "show second address");
    do_reset();
    chk(lmp.config_mode_lamp, 1'b0, "mode kept over reset");
    press();
    chk({lmp.config_mode_lamp, lmp.config_mismatch_lamp, nvq}, 3'b100, "back to config");
    // show in configuration mode walks the present slaves
    present <= 32'h30;
    repeat (4) @(posedge clk);
    sbtn <= 1'b1;
    repeat (3) @(posedge clk);
    sbtn <= 1'b0;
    repeat (4) @(posedge clk);
    chk(seg, 8'h04, "show first present");
    repeat (8) @(posedge clk);
    chk(seg, 8'h05, "show next present");
    // short press enters protection without registering
    mbtn <= 1'b1;
    repeat (8) @(posedge clk);
    mbtn <= 1'b0;
    repeat (12) @(posedge clk);
    chk({lmp.config_mode_lamp, lmp.auto_addr_lamp, nvq}, 3'b001, "short press protect entry");
    wb(1'b0, ADR_REG_CFG, 32'h0);
    chk(q, 32'h0, "short press not registered");
    finish_test();
  end
endmodule : asi_gateway_fault_status_tb
`default_nettype wire
